// ### logic/tai_inval_addr.sv
// Purpose: Write-only invalidate address register and page-selective request issue
// Assumes: Simple register port, read data one cycle after read strobe
// Notes:   Engine handshake via o_inv_valid / i_inv_done
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/10ps
// Function
// R01 - Address register write-only, reads return constant
// R02 - 64-bit aligned offset, reported in capability
// R03 - Software places address in bits 63:12
// R04 - Software writes address before page command
// R05 - Address bits at and above MAX_GUEST_ADDR_WIDTH ignored
// R06 - Hint zero flushes leaf and paging caches
// R07 - Hint one may keep paging caches
// R08 - Hint one only if non-leaf unmodified
// R09 - Software programs domain id within width
// R10 - Mask M covers 2^M aligned pages
module tai_inval_addr
	import tai_pkg::*;
#(
	parameter int MAX_GUEST_ADDR_WIDTH = TAI_MAX_GUEST_ADDR_WIDTH_DEF,
	parameter int DIDW = TAI_DIDW_DEF
) (
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic [11:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic             o_inv_valid,
	output logic      [51:0] o_inv_base,
	output logic      [51:0] o_inv_span,
	output logic      [15:0] o_inv_domain,
	output logic             o_inv_leaf_only,
	output logic             o_inv_paging_flush,
	input  wire logic        i_inv_done
);
	if (MAX_GUEST_ADDR_WIDTH < 13 || MAX_GUEST_ADDR_WIDTH > 64 || DIDW < 1 || DIDW > 16) begin : g_bad_param
		$error("tai_inval_addr: unsupported MAX_GUEST_ADDR_WIDTH or DIDW");
	end

	localparam logic [TAI_IRO_W-1:0] IRO_VAL = TAI_IRO_W'(TAI_ADDR_LO_OFF >> 4);

	logic [31:0]           addr_lo_ff;
	logic [31:0]           addr_hi_ff;
	logic [15:0]           did_ff;
	logic [31:0]           rdata_ff;
	tai_state_t            state_ff;
	tai_state_t            nxt_state;
	logic                  valid_ff;
	logic [51:0]           base_ff;
	logic [51:0]           span_ff;
	logic                  leaf_ff;
	logic                  pflush_ff;
	logic [15:0]           dom_ff;
	logic [7:0]            done_cnt_ff;
	logic [51:0]           base_c;
	logic [51:0]           span_c;
	logic                  go;

	// Write-only address register; stored bits only
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			addr_lo_ff <= TAI_RST_WORD;
			addr_hi_ff <= TAI_RST_WORD;
		end else if (i_wr && i_addr == TAI_ADDR_LO_OFF) begin
			addr_lo_ff <= {i_wdata[31:TAI_ADDR_LSB], 5'h00, i_wdata[TAI_HINT_BIT:0]};
		end else if (i_wr && i_addr == TAI_ADDR_HI_OFF) begin
			addr_hi_ff <= i_wdata; // R03
		end
	end

	// Domain field of companion command register
	always_ff @(posedge i_clk) begin
		if (!i_reset_n)
			did_ff <= 16'h0000;
		else if (i_wr && i_addr == TAI_CMD_HI_OFF)
			did_ff <= i_wdata[15:0] & 16'((32'h1 << DIDW) - 1); // R09
	end

	assign go = i_wr && i_addr == TAI_CMD_LO_OFF && i_wdata[TAI_CMD_GO_BIT]
		&& i_wdata[TAI_CMD_GRAN_LSB+:2] == TAI_GRAN_PAGE;

	tai_addr_mask #(
		.MAX_GUEST_ADDR_WIDTH (MAX_GUEST_ADDR_WIDTH)
	) i_tai_addr_mask (
		.i_page      ({addr_hi_ff, addr_lo_ff[31:TAI_ADDR_LSB]}),
		.i_mask      (addr_lo_ff[TAI_MASK_LSB+:TAI_MASK_W]),
		.o_base      (base_c),
		.o_span_mask (span_c)
	);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			TAI_IDLE:  if (go) nxt_state = TAI_ISSUE; // R04
			TAI_ISSUE: nxt_state = TAI_WAIT;
			TAI_WAIT:  if (i_inv_done) nxt_state = TAI_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n)
			state_ff <= TAI_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Request snapshot taken when the page command lands
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			valid_ff  <= 1'b0;
			base_ff   <= '0;
			span_ff   <= '0;
			leaf_ff   <= 1'b0;
			pflush_ff <= 1'b0;
			dom_ff    <= 16'h0000;
		end else begin
			valid_ff <= (nxt_state == TAI_ISSUE) || (state_ff != TAI_IDLE && nxt_state != TAI_IDLE);
			if (state_ff == TAI_IDLE && go) begin
				base_ff   <= base_c; // R05 R10
				span_ff   <= span_c; // R10
				dom_ff    <= did_ff;
				leaf_ff   <= addr_lo_ff[TAI_HINT_BIT]; // R07
				pflush_ff <= ~addr_lo_ff[TAI_HINT_BIT]; // R06
			end
		end
	end

	// Busy flag and completion count readable
	always_ff @(posedge i_clk) begin
		if (!i_reset_n)
			done_cnt_ff <= 8'h00;
		else if (state_ff == TAI_WAIT && i_inv_done)
			done_cnt_ff <= done_cnt_ff + 8'h01;
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			rdata_ff <= 32'h00000000;
		end else if (i_rd) begin
			unique case (i_addr)
				TAI_ADDR_LO_OFF, TAI_ADDR_HI_OFF: rdata_ff <= TAI_UNDEF_READ; // R01
				TAI_ECAP_LO_OFF: rdata_ff <= 32'(IRO_VAL) << TAI_IRO_LSB; // R02
				TAI_CMD_HI_OFF:  rdata_ff <= {16'h0000, did_ff};
				TAI_STAT_OFF:    rdata_ff <= {23'h000000, state_ff != TAI_IDLE, done_cnt_ff};
				default:         rdata_ff <= 32'h00000000;
			endcase
		end else begin
			rdata_ff <= 32'h00000000;
		end
	end

	assign o_rdata            = rdata_ff;
	assign o_inv_valid        = valid_ff;
	assign o_inv_base         = base_ff;
	assign o_inv_span         = span_ff;
	assign o_inv_domain       = dom_ff;
	assign o_inv_leaf_only    = leaf_ff;
	assign o_inv_paging_flush = pflush_ff;

	property p_r01_ro;
		@(posedge i_clk) disable iff (!i_reset_n)
		i_rd && (i_addr == TAI_ADDR_LO_OFF || i_addr == TAI_ADDR_HI_OFF) |=> o_rdata == TAI_UNDEF_READ;
	endproperty
	a_r01_ro: assert property (p_r01_ro) else $error("address read not constant"); // R01

	property p_r02_iro;
		@(posedge i_clk) disable iff (!i_reset_n)
		i_rd && i_addr == TAI_ECAP_LO_OFF
		|=> o_rdata[TAI_IRO_LSB+:TAI_IRO_W] == IRO_VAL && TAI_ADDR_LO_OFF[2:0] == 3'h0;
	endproperty
	a_r02_iro: assert property (p_r02_iro) else $error("offset report wrong"); // R02

	property p_r06_flush;
		@(posedge i_clk) disable iff (!i_reset_n)
		state_ff == TAI_IDLE && go && !addr_lo_ff[TAI_HINT_BIT]
		|=> o_inv_paging_flush && !o_inv_leaf_only;
	endproperty
	a_r06_flush: assert property (p_r06_flush) else $error("hint zero without flush"); // R06

	property p_r07_keep;
		@(posedge i_clk) disable iff (!i_reset_n)
		state_ff == TAI_IDLE && go && addr_lo_ff[TAI_HINT_BIT]
		|=> o_inv_leaf_only && !o_inv_paging_flush;
	endproperty
	a_r07_keep: assert property (p_r07_keep) else $error("hint one not leaf only"); // R07

	property p_r05_max_guest_addr_width;
		@(posedge i_clk) disable iff (!i_reset_n)
		o_inv_valid |-> (o_inv_base >> (MAX_GUEST_ADDR_WIDTH - 12)) == 52'h0;
	endproperty
	a_r05_max_guest_addr_width: assert property (p_r05_max_guest_addr_width) else $error("address above width"); // R05

	property p_r10_span;
		@(posedge i_clk) disable iff (!i_reset_n)
		state_ff == TAI_IDLE && go |=> o_inv_span == (52'h1 << $past(addr_lo_ff[5:0])) - 52'h1
			&& (o_inv_base & o_inv_span) == 52'h0;
	endproperty
	a_r10_span: assert property (p_r10_span) else $error("mask span wrong"); // R10

	property p_r04_issue;
		@(posedge i_clk) disable iff (!i_reset_n)
		state_ff == TAI_IDLE && go |=> o_inv_valid ##0 o_inv_domain == $past(did_ff);
	endproperty
	a_r04_issue: assert property (p_r04_issue) else $error("page request not issued"); // R04

	property p_hold;
		@(posedge i_clk) disable iff (!i_reset_n)
		o_inv_valid && !i_inv_done |=> o_inv_valid && $stable(o_inv_base);
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped before done");

	c_hint0: cover property (@(posedge i_clk) go && !addr_lo_ff[TAI_HINT_BIT]);
	c_hint1: cover property (@(posedge i_clk) go && addr_lo_ff[TAI_HINT_BIT]);
	c_done:  cover property (@(posedge i_clk) state_ff == TAI_WAIT && i_inv_done);
	c_busy:  cover property (@(posedge i_clk) state_ff != TAI_IDLE && go);
	c_issue: cover property (@(posedge i_clk) state_ff == TAI_ISSUE);

	property p_rd_idle;
		@(posedge i_clk) disable iff (!i_reset_n)
		!i_rd |=> o_rdata == 32'h00000000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

	// Command while busy must leave the pending request alone
	property p_busy_ignore;
		@(posedge i_clk) disable iff (!i_reset_n)
		state_ff != TAI_IDLE && go |=> $stable(o_inv_domain) && $stable(o_inv_base);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy"); // R04
endmodule

// ### logic/tai_pkg.sv
// Purpose: Shared constants for the translation-cache invalidate address block
// Assumes: 32-bit register port, 64-bit registers split into two word halves
// Notes:   Offsets are byte addresses, each 64-bit register on an 8-byte boundary
package tai_pkg;
	localparam logic [11:0] TAI_ADDR_LO_OFF   = 12'h0a0;
	localparam logic [11:0] TAI_ADDR_HI_OFF   = 12'h0a4;
	localparam logic [11:0] TAI_CMD_LO_OFF    = 12'h0a8;
	localparam logic [11:0] TAI_CMD_HI_OFF    = 12'h0ac;
	localparam logic [11:0] TAI_ECAP_LO_OFF   = 12'h010;
	localparam logic [11:0] TAI_STAT_OFF      = 12'h0b0;
	localparam int          TAI_MASK_LSB      = 0;
	localparam int          TAI_MASK_W        = 6;
	localparam int          TAI_HINT_BIT      = 6;
	localparam int          TAI_ADDR_LSB      = 12;
	localparam int          TAI_DID_LSB       = 32;
	localparam int          TAI_IRO_LSB       = 8;
	localparam int          TAI_IRO_W         = 10;
	localparam int          TAI_CMD_GO_BIT    = 31;
	localparam int          TAI_CMD_GRAN_LSB  = 28;
	localparam logic [1:0]  TAI_GRAN_PAGE     = 2'h3;
	localparam logic [31:0] TAI_RST_WORD      = 32'h00000000;
	localparam logic [31:0] TAI_UNDEF_READ    = 32'h00000000;
	localparam int          TAI_MAX_GUEST_ADDR_WIDTH_DEF      = 48;
	localparam int          TAI_DIDW_DEF      = 16;
	localparam int          TAI_ISSUE_CYC     = 1;
	typedef enum logic [1:0] {TAI_IDLE, TAI_ISSUE, TAI_WAIT} tai_state_t;
endpackage

// ### logic/tai_addr_mask.sv
// Purpose: Forms the effective invalidation base and span from address and mask
// Assumes: Combinational, used inside the invalidate address block
// Notes:   Page numbers only; base bits above the guest address width forced to zero
`timescale 1ns/10ps
module tai_addr_mask
	import tai_pkg::*;
#(
	parameter int MAX_GUEST_ADDR_WIDTH = TAI_MAX_GUEST_ADDR_WIDTH_DEF
) (
	input  wire logic [51:0]           i_page,
	input  wire logic [TAI_MASK_W-1:0] i_mask,
	output logic      [51:0]           o_base,
	output logic      [51:0]           o_span_mask
);
	if (MAX_GUEST_ADDR_WIDTH < 13 || MAX_GUEST_ADDR_WIDTH > 64) begin : g_bad_param
		$error("tai_addr_mask: unsupported MAX_GUEST_ADDR_WIDTH");
	end

	logic [51:0] keep;
	genvar g;
	generate
		for (g = 0; g < 52; g++) begin : g_bit
			// Page bit g is address bit g+12
			assign keep[g]        = (g + 12) < MAX_GUEST_ADDR_WIDTH; // R05
			assign o_span_mask[g] = g < i_mask; // R10
			assign o_base[g]      = i_page[g] & keep[g] & ~o_span_mask[g]; // R05 R10
		end
	endgenerate
endmodule

// ### verification/tai_inval_addr_tb.sv
// Purpose: Self-checking bench for the invalidate address register block
// Assumes: Register port with read data in the cycle after the read strobe
// Notes:   Engine side driven by the bench; MAX_GUEST_ADDR_WIDTH 48, DIDW 16
`timescale 1ns/10ps
module tai_inval_addr_tb import tai_pkg::*;;
	localparam int MAX_GUEST_ADDR_WIDTH = 48;
	logic        i_clk;
	logic        i_reset_n;
	logic [11:0] i_addr;
	logic [31:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic        i_inv_done;
	logic [31:0] o_rdata;
	logic        o_inv_valid;
	logic [51:0] o_inv_base;
	logic [51:0] o_inv_span;
	logic [15:0] o_inv_domain;
	logic        o_inv_leaf_only;
	logic        o_inv_paging_flush;
	int          miscompares;
	int          checked;
	logic [31:0] d;
	logic [31:0] lo;
	logic [31:0] hi;
	logic [51:0] p;
	int          m;

	tai_inval_addr #(.MAX_GUEST_ADDR_WIDTH(MAX_GUEST_ADDR_WIDTH), .DIDW(16)) i_tai_inval_addr (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_inv_valid(o_inv_valid),
		.o_inv_base(o_inv_base), .o_inv_span(o_inv_span), .o_inv_domain(o_inv_domain),
		.o_inv_leaf_only(o_inv_leaf_only), .o_inv_paging_flush(o_inv_paging_flush),
		.i_inv_done(i_inv_done));

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	task chk(input string name, input logic [51:0] exp, input logic [51:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] v);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask

	task rd(input logic [11:0] a, output logic [31:0] v);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		v = o_rdata;
		@(posedge i_clk);
	endtask

	task results;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#(100 * 3000);
		miscompares++;
		results();
	end

	initial begin
		miscompares = 0;
		checked = 0;
		i_reset_n = 1'b0;
		i_addr = 12'h000;
		i_wdata = 32'h00000000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_inv_done = 1'b0;
		repeat (5) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		chk("reset_valid", 52'h0, 52'(o_inv_valid));
		chk("reset_base", 52'h0, o_inv_base);
		chk("reset_rdata", 52'h0, 52'(o_rdata));
		wr(TAI_ADDR_LO_OFF, 32'h12345678);
		rd(TAI_ADDR_LO_OFF, d);
		chk("addr_lo_read", 52'(TAI_UNDEF_READ), 52'(d));
		rd(TAI_ADDR_HI_OFF, d);
		chk("addr_hi_read", 52'(TAI_UNDEF_READ), 52'(d));
		rd(TAI_ECAP_LO_OFF, d);
		chk("ecap_offset", 52'(TAI_ADDR_LO_OFF >> 4), 52'(d[17:8]));
		rd(12'hffc, d);
		chk("unmapped_read", 52'h0, 52'(d));
		wr(TAI_CMD_LO_OFF, 32'h90000000);
		#1;
		chk("non_page_cmd", 52'h0, 52'(o_inv_valid));
		@(posedge i_clk);
		wr(TAI_CMD_LO_OFF, 32'h30000000);
		#1;
		chk("no_go_cmd", 52'h0, 52'(o_inv_valid));
		@(posedge i_clk);
		$display("test register reads done");
		for (int i = 0; i < 2; i++) begin
			m = (i == 0) ? 3 : 9;
			lo = 32'h0dcba000 | (32'(i) << 6) | 32'(m);
			hi = 32'hffff8421;
			wr(TAI_ADDR_LO_OFF, lo);
			wr(TAI_ADDR_HI_OFF, hi);
			wr(TAI_CMD_HI_OFF, 32'hffff1230 + 32'(i));
			wr(TAI_CMD_LO_OFF, 32'hb0000000);
			#1;
			p = {hi, lo[31:12]} & ((52'h1 << (MAX_GUEST_ADDR_WIDTH - 12)) - 52'h1);
			p = p & ~((52'h1 << m) - 52'h1);
			chk("valid", 52'h1, 52'(o_inv_valid));
			chk("base", p, o_inv_base);
			chk("span", (52'h1 << m) - 52'h1, o_inv_span);
			chk("domain", 52'h1230 + 52'(i), 52'(o_inv_domain));
			chk("leaf_only", 52'(i), 52'(o_inv_leaf_only));
			chk("paging_flush", 52'(1 - i), 52'(o_inv_paging_flush));
			@(posedge i_clk);
			wr(TAI_ADDR_LO_OFF, 32'h00000000);
			wr(TAI_CMD_LO_OFF, 32'hb0000000);
			#1;
			chk("base_held_busy", p, o_inv_base);
			@(posedge i_clk);
			rd(TAI_STAT_OFF, d);
			chk("busy", 52'h1, 52'(d[8]));
			rd(TAI_CMD_HI_OFF, d);
			chk("domain_read", 52'h1230 + 52'(i), 52'(d));
			i_inv_done <= 1'b1;
			@(posedge i_clk);
			i_inv_done <= 1'b0;
			#1;
			chk("valid_drop", 52'h0, 52'(o_inv_valid));
			@(posedge i_clk);
			rd(TAI_STAT_OFF, d);
			chk("done_count", 52'(i + 1), 52'(d[7:0]));
			$display("test invalidation %0d done", i);
		end
		results();
	end
endmodule
